// >>> rtl/pfc_valley_switching_control.sv
// Purpose: Boost stage switching control with shared sense pin, valley selection and soft start.
// Assumes: Comparator outputs are asynchronous; ADC strobes are on clk.
// Notes: Registers reached over Avalon-MM; one wait cycle per access.
// Function
// - While gate is on, sense pin is current sense for overcurrent cut.
// - While gate is off, sense pin is the valley detect input.
// - Current sense ignored until programmable blanking elapses after turn-on.
// - Valley event is a falling edge of hysteretic comparator versus positive level.
// - Count valleys in off-time, turn on at selected valley number.
// - First-valley mode uses constant on-time; off-time follows input voltage.
// - In first-valley mode the next cycle starts at once on first valley.
// - Light load may select later valleys up to configured maximum count.
// - Valley n adds n-1 resonant periods after the first valley.
// - Bus ADC has wide zero-to-reference and narrow five- to seven-sixths range.
// - Narrow range in steady state, wide range during soft start.
// - PI bus regulator active in both soft start and steady state.
// - Soft start begins when bus exceeds the start threshold (brown-in).
// - Input under- or overvoltage during soft start aborts it.
// - Soft start stays on the first valley.
// - Steady state entered when bus reaches steady entry threshold.
// - Desired on-time held constant over each mains half cycle.
// - Desired on-time grows as emulated load resistance falls.
// - Valley choice keeps switching frequency between configured limits.
// - Line sense feeds protection, mains zero-crossing and AC/DC detection.
// - Valley up at upper frequency limit, down at lower, else unchanged.
// - Turn on at selected valley or at period timeout, whichever first.
`timescale 1ns/100ps
module pfc_valley_switching_control
  import pfc_pkg::*;
#(
  parameter int DC_CYCLES = pfc_pkg::DC_DETECT_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Avalon-MM slave
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Shared sense pin comparators
  input wire logic boost_sense_pin_valley,
  input wire logic boost_sense_pin_ocp,
  // Bus voltage ADC
  input wire logic bus_adc_valid,
  input wire logic bus_adc_narrow,
  input wire logic [pfc_pkg::ADC_W-1:0] bus_sense_pin_code,
  output logic bus_range_narrow,
  // Line voltage ADC
  input wire logic line_adc_valid,
  input wire logic [pfc_pkg::ADC_W-1:0] line_sense_pin_code,
  // Gate drive and status
  output logic boost_gate,
  output logic half_cycle_pulse,
  output logic dc_source
);
  import pfc_pkg::*;

  logic [31:0] ctrl_q, blank_q, start_q, steady_q, setpt_q, plim_q, tmo_q, llim_q, gains_q;
  logic wait_q;
  mode_t mode_q;
  gate_t g_st_q;
  logic [CNT_W-1:0] on_cnt_q, per_cnt_q, ton_q;
  logic [VAL_W-1:0] valley_cnt_q, valley_sel_q, max_valley;
  logic [2:0] vcmp_q, ocp_q;
  logic valley_evt, ocp_s, run, turn_on, on_done, ocp_cut;
  logic [LVL_W-1:0] bus_lvl_q;
  logic bus_new_q;
  logic line_fault_q, line_above_q, half_q, dc_q;
  logic [31:0] dc_cnt_q;
  logic [CNT_W-1:0] desired_on_time;
  logic acc, wr_en;

  // Merge write data into a register under byte enables
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Map either ADC range onto one wide-scale level
  function automatic logic [LVL_W-1:0] to_level(input logic narrow, input logic [ADC_W-1:0] code);
    logic [LVL_W-1:0] r;
    r = narrow ? (NARROW_BASE + LVL_W'(code / 3)) : {1'b0, code};
    return r;
  endfunction

  assign acc = read | write;
  assign wr_en = write & ~wait_q;
  assign max_valley = ctrl_q[CTRL_MAXV_LSB +: VAL_W];

  // One wait cycle: the request is taken at the edge where waitrequest is low
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= ~(acc & wait_q);
    end
  end
  assign waitrequest = wait_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_q <= RST_CTRL;
      blank_q <= RST_BLANK;
      start_q <= RST_START_LVL;
      steady_q <= RST_STEADY_LVL;
      setpt_q <= RST_BUS_SETPT;
      plim_q <= RST_PERIOD_LIM;
      tmo_q <= RST_TIMEOUT;
      llim_q <= RST_LINE_LIM;
      gains_q <= RST_GAINS;
    end else if (wr_en) begin
      case (address)
        OFS_CTRL: ctrl_q <= merge(ctrl_q, writedata, byteenable);
        OFS_BLANK: blank_q <= merge(blank_q, writedata, byteenable);
        OFS_START_LVL: start_q <= merge(start_q, writedata, byteenable);
        OFS_STEADY_LVL: steady_q <= merge(steady_q, writedata, byteenable);
        OFS_BUS_SETPT: setpt_q <= merge(setpt_q, writedata, byteenable);
        OFS_PERIOD_LIM: plim_q <= merge(plim_q, writedata, byteenable);
        OFS_TIMEOUT: tmo_q <= merge(tmo_q, writedata, byteenable);
        OFS_LINE_LIM: llim_q <= merge(llim_q, writedata, byteenable);
        OFS_GAINS: gains_q <= merge(gains_q, writedata, byteenable);
        default: ;
      endcase
    end
  end

  // Read data is captured in the wait cycle and stands while waitrequest is low
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      readdata <= '0;
    end else if (read & wait_q) begin
      case (address)
        OFS_CTRL: readdata <= ctrl_q;
        OFS_BLANK: readdata <= blank_q;
        OFS_START_LVL: readdata <= start_q;
        OFS_STEADY_LVL: readdata <= steady_q;
        OFS_BUS_SETPT: readdata <= setpt_q;
        OFS_PERIOD_LIM: readdata <= plim_q;
        OFS_TIMEOUT: readdata <= tmo_q;
        OFS_LINE_LIM: readdata <= llim_q;
        OFS_GAINS: readdata <= gains_q;
        OFS_STATUS: readdata <= {20'h00000, valley_sel_q, 2'b00, dc_q, line_fault_q, boost_gate, 1'b0, mode_q};
        OFS_ON_TIME: readdata <= {16'h0000, desired_on_time};
        default: readdata <= '0;
      endcase
    end
  end

  // Comparator inputs are asynchronous: two flops, a third only for edge detect
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      vcmp_q <= '0;
      ocp_q <= '0;
    end else begin
      vcmp_q <= {vcmp_q[1:0], boost_sense_pin_valley};
      ocp_q <= {ocp_q[1:0], boost_sense_pin_ocp};
    end
  end
  assign valley_evt = vcmp_q[2] & ~vcmp_q[1];
  assign ocp_s = ocp_q[1];

  // Bus level in a common scale regardless of range
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bus_lvl_q <= '0;
      bus_new_q <= 1'b0;
    end else begin
      bus_new_q <= bus_adc_valid;
      if (bus_adc_valid) begin
        bus_lvl_q <= to_level(bus_adc_narrow, bus_sense_pin_code);
      end
    end
  end

  // Line sense: protection window, zero-crossing and DC detection
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      line_fault_q <= 1'b0;
      line_above_q <= 1'b0;
      half_q <= 1'b0;
      dc_q <= 1'b0;
      dc_cnt_q <= '0;
    end else begin
      half_q <= 1'b0;
      if (line_adc_valid) begin
        line_fault_q <= (line_sense_pin_code < llim_q[ADC_W-1:0]) ||
                        (line_sense_pin_code > llim_q[LIM_HI_LSB +: ADC_W]);
        line_above_q <= line_sense_pin_code > LINE_ZC_LEVEL;
      end
      if (line_adc_valid && line_above_q && line_sense_pin_code <= LINE_ZC_LEVEL) begin
        half_q <= 1'b1;
        dc_q <= 1'b0;
        dc_cnt_q <= '0;
      end else if (dc_cnt_q >= 32'(DC_CYCLES - 1)) begin
        // No mains crossing: DC source, still refresh the on-time
        half_q <= 1'b1;
        dc_q <= 1'b1;
        dc_cnt_q <= '0;
      end else begin
        dc_cnt_q <= dc_cnt_q + 32'h1;
      end
    end
  end
  assign half_cycle_pulse = half_q;
  assign dc_source = dc_q;

  bus_pi_regulator u_reg (
    .clk(clk),
    .rstn(rstn),
    .sample_valid(bus_new_q),
    .bus_level(bus_lvl_q),
    .setpoint(setpt_q[LVL_W-1:0]),
    .kp(gains_q[7:0]),
    .ki(gains_q[GAIN_KI_LSB +: 8]),
    .half_cycle(half_q),
    .desired_on_time(desired_on_time)
  );

  // Start-up sequence
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mode_q <= M_WAIT;
    end else begin
      case (mode_q)
        M_WAIT: if (ctrl_q[CTRL_EN_BIT] && !line_fault_q && bus_lvl_q > start_q[LVL_W-1:0]) begin
          mode_q <= M_SOFT;
        end
        M_SOFT: if (line_fault_q || !ctrl_q[CTRL_EN_BIT]) begin
          mode_q <= M_WAIT;
        end else if (bus_lvl_q >= steady_q[LVL_W-1:0]) begin
          mode_q <= M_STEADY;
        end
        M_STEADY: if (!ctrl_q[CTRL_EN_BIT]) begin
          mode_q <= M_WAIT;
        end
        default: mode_q <= M_WAIT;
      endcase
    end
  end

  // Coarse range while the bus climbs, fine range once regulated
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bus_range_narrow <= 1'b0;
    end else begin
      bus_range_narrow <= (mode_q == M_STEADY);
    end
  end

  assign run = (mode_q != M_WAIT) && !line_fault_q;
  assign on_done = (on_cnt_q + 16'h1) >= ton_q;
  assign ocp_cut = ocp_s && (on_cnt_q >= blank_q[CNT_W-1:0]);
  // Valley n is reached after n-1 further resonant periods past the first
  assign turn_on = (g_st_q == G_OFF) && run &&
                   ((valley_evt && (valley_cnt_q + 4'h1) >= valley_sel_q) ||
                    (per_cnt_q >= tmo_q[CNT_W-1:0]));

  // Switching cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      g_st_q <= G_IDLE;
      boost_gate <= 1'b0;
      on_cnt_q <= '0;
      per_cnt_q <= '0;
      ton_q <= ON_TIME_MIN;
      valley_cnt_q <= '0;
    end else begin
      if (per_cnt_q != 16'hFFFF) begin
        per_cnt_q <= per_cnt_q + 16'h1;
      end
      case (g_st_q)
        G_IDLE: if (run) begin
          g_st_q <= G_ON;
          boost_gate <= 1'b1;
          on_cnt_q <= '0;
          per_cnt_q <= '0;
          ton_q <= desired_on_time;
        end
        G_ON: begin
          on_cnt_q <= on_cnt_q + 16'h1;
          if (on_done || ocp_cut || !run) begin
            g_st_q <= G_OFF;
            boost_gate <= 1'b0;
            valley_cnt_q <= '0;
          end
        end
        G_OFF: if (!run) begin
          g_st_q <= G_IDLE;
        end else if (turn_on) begin
          g_st_q <= G_ON;
          boost_gate <= 1'b1;
          on_cnt_q <= '0;
          per_cnt_q <= '0;
          ton_q <= desired_on_time;
        end else if (valley_evt && valley_cnt_q != 4'hF) begin
          valley_cnt_q <= valley_cnt_q + 4'h1;
        end
        default: g_st_q <= G_IDLE;
      endcase
    end
  end

  // Frequency law, judged on each finished period
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      valley_sel_q <= 4'h1;
    end else if (mode_q != M_STEADY) begin
      valley_sel_q <= 4'h1;
    end else if (valley_sel_q > max_valley && max_valley != 4'h0) begin
      valley_sel_q <= max_valley;
    end else if (turn_on) begin
      if (per_cnt_q < plim_q[CNT_W-1:0] && valley_sel_q < max_valley) begin
        valley_sel_q <= valley_sel_q + 4'h1;
      end else if (per_cnt_q > plim_q[LIM_HI_LSB +: CNT_W] && valley_sel_q > 4'h1) begin
        valley_sel_q <= valley_sel_q - 4'h1;
      end
    end
  end

  a_ocp_cuts_gate: assert property (@(posedge clk) disable iff (!rstn)
    g_st_q == G_ON && ocp_s && on_cnt_q >= blank_q[CNT_W-1:0] |=> !boost_gate)
    else $error("overcurrent after blanking did not end the on-time");
  a_blank_holds_gate: assert property (@(posedge clk) disable iff (!rstn)
    g_st_q == G_ON && on_cnt_q < blank_q[CNT_W-1:0] && !on_done && run |=> boost_gate)
    else $error("gate ended inside the blanking interval");
  a_valley_turns_on: assert property (@(posedge clk) disable iff (!rstn)
    g_st_q == G_OFF && run && valley_evt && valley_cnt_q + 4'h1 >= valley_sel_q |=> boost_gate)
    else $error("selected valley did not start the next cycle");
  a_on_has_cause: assert property (@(posedge clk) disable iff (!rstn)
    $rose(boost_gate) && $past(g_st_q) == G_OFF |->
      $past(valley_evt) || $past(per_cnt_q) >= $past(tmo_q[CNT_W-1:0]))
    else $error("turn-on without valley or timeout");
  a_soft_first_valley: assert property (@(posedge clk) disable iff (!rstn)
    mode_q == M_SOFT ##1 mode_q == M_SOFT |-> valley_sel_q == 4'h1)
    else $error("later valley used during soft start");
  a_valley_in_range: assert property (@(posedge clk) disable iff (!rstn)
    turn_on && mode_q == M_STEADY && valley_sel_q <= max_valley |=> valley_sel_q <= max_valley && valley_sel_q >= 4'h1)
    else $error("valley selection left its bounds");
  a_count_cleared: assert property (@(posedge clk) disable iff (!rstn)
    $fell(boost_gate) |-> valley_cnt_q == 4'h0)
    else $error("valley counter not cleared at turn-off");
  a_soft_abort: assert property (@(posedge clk) disable iff (!rstn)
    mode_q == M_SOFT && line_fault_q |=> mode_q == M_WAIT ##1 !boost_gate)
    else $error("soft start not aborted on line fault");
  a_range_follows: assert property (@(posedge clk) disable iff (!rstn)
    mode_q == M_STEADY ##1 mode_q == M_STEADY |-> bus_range_narrow)
    else $error("wide range used in steady state");
endmodule

// >>> rtl/pfc_pkg.sv
// Purpose: Shared constants for the boost stage valley switching control.
// Assumes: 125 MHz system clock, 32-bit Avalon-MM register bus with byte addresses.
// Notes: Offsets are byte addresses of aligned 32-bit words.
package pfc_pkg;
  localparam int CLK_MHZ = 125;
  localparam int ADC_W = 12;
  localparam int LVL_W = 13;
  localparam int CNT_W = 16;
  localparam int VAL_W = 4;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_BLANK = 8'h04;
  localparam logic [7:0] OFS_START_LVL = 8'h08;
  localparam logic [7:0] OFS_STEADY_LVL = 8'h0C;
  localparam logic [7:0] OFS_BUS_SETPT = 8'h10;
  localparam logic [7:0] OFS_PERIOD_LIM = 8'h14;
  localparam logic [7:0] OFS_TIMEOUT = 8'h18;
  localparam logic [7:0] OFS_LINE_LIM = 8'h1C;
  localparam logic [7:0] OFS_GAINS = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;
  localparam logic [7:0] OFS_ON_TIME = 8'h28;

  // Field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_MAXV_LSB = 4;
  localparam int LIM_HI_LSB = 16;
  localparam int GAIN_KI_LSB = 8;

  // Reset values
  localparam logic [31:0] RST_CTRL = 32'h0000_0040;
  localparam logic [31:0] RST_BLANK = 32'h0000_0020;
  localparam logic [31:0] RST_START_LVL = 32'h0000_0800;
  localparam logic [31:0] RST_STEADY_LVL = 32'h0000_0D00;
  localparam logic [31:0] RST_BUS_SETPT = 32'h0000_1000;
  localparam logic [31:0] RST_PERIOD_LIM = 32'h2710_01F4;
  localparam logic [31:0] RST_TIMEOUT = 32'h0000_3A98;
  localparam logic [31:0] RST_LINE_LIM = 32'h0F00_0100;
  localparam logic [31:0] RST_GAINS = 32'h0000_0410;

  // Narrow range spans 5/6 to 7/6 of the reference: base 5/6 of full scale, step 1/3
  localparam logic [LVL_W-1:0] NARROW_BASE = 13'h0D55;
  localparam logic [ADC_W-1:0] LINE_ZC_LEVEL = 12'h040;

  // Mains absent for this long means a DC source
  localparam int DC_DETECT_MS = 20;
  localparam int DC_DETECT_CYCLES = DC_DETECT_MS * CLK_MHZ * 1000;

  localparam logic [CNT_W-1:0] ON_TIME_MIN = 16'h0010;
  localparam logic [CNT_W-1:0] ON_TIME_MAX = 16'h0FA0;
  localparam int PI_SHIFT = 6;

  typedef enum logic [1:0] {M_WAIT, M_SOFT, M_STEADY} mode_t;
  typedef enum logic [1:0] {G_IDLE, G_ON, G_OFF} gate_t;
endpackage

// >>> rtl/bus_pi_regulator.sv
// Purpose: Proportional-integral bus voltage regulator giving the desired on-time.
// Assumes: Samples arrive as single-cycle strobes on the system clock.
// Notes: Output changes only on the half-cycle strobe.
`timescale 1ns/100ps
module bus_pi_regulator
  import pfc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Measurement
  input wire logic sample_valid,
  input wire logic [pfc_pkg::LVL_W-1:0] bus_level,
  input wire logic [pfc_pkg::LVL_W-1:0] setpoint,
  input wire logic [7:0] kp,
  input wire logic [7:0] ki,
  // Hold control
  input wire logic half_cycle,
  output logic [pfc_pkg::CNT_W-1:0] desired_on_time
);
  import pfc_pkg::*;

  localparam logic signed [27:0] INTEG_MAX = 28'sh00FFFFF;
  logic signed [LVL_W:0] err;
  logic signed [27:0] integ_q;
  logic signed [27:0] integ_sum;
  logic signed [27:0] pi_sum;
  logic signed [27:0] pi_scaled;

  // A low bus means more load, so positive error lengthens the on-time
  assign err = $signed({1'b0, setpoint}) - $signed({1'b0, bus_level});
  assign integ_sum = integ_q + 28'(err * $signed({1'b0, ki}));
  assign pi_sum = integ_q + 28'(err * $signed({1'b0, kp}));
  assign pi_scaled = pi_sum >>> PI_SHIFT;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      integ_q <= '0;
    end else if (sample_valid) begin
      if (integ_sum > INTEG_MAX) begin
        integ_q <= INTEG_MAX;
      end else if (integ_sum < 0) begin
        integ_q <= '0;
      end else begin
        integ_q <= integ_sum;
      end
    end
  end

  // Held between half-cycle strobes so the on-time is flat across each mains half cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      desired_on_time <= ON_TIME_MIN;
    end else if (half_cycle) begin
      if (pi_scaled < $signed({12'h000, ON_TIME_MIN})) begin
        desired_on_time <= ON_TIME_MIN;
      end else if (pi_scaled > $signed({12'h000, ON_TIME_MAX})) begin
        desired_on_time <= ON_TIME_MAX;
      end else begin
        desired_on_time <= pi_scaled[CNT_W-1:0];
      end
    end
  end

  a_on_time_held: assert property (@(posedge clk) disable iff (!rstn)
    !half_cycle |=> $stable(desired_on_time))
    else $error("on-time changed outside a half-cycle strobe");
endmodule

// >>> tb/boost_stage_model.sv
// Purpose: Behavioural boost power stage: choke ringing after turn-off and shunt overcurrent.
// Assumes: Valley comparator reads high above the valley level and low while the switch conducts.
// Notes: Ringing dies after nine valleys; no_ring models a choke that never demagnetises.
`timescale 1ns/100ps
module boost_stage_model #(
  parameter int DEMAG = 40,
  parameter int RING = 20
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Gate and commands from the bench
  input wire logic gate,
  input wire logic no_ring,
  input wire logic ocp_req,
  // Comparator outputs
  output logic valley,
  output logic ocp
);
  int t;
  logic gate_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      t <= 0;
      gate_q <= 1'b0;
      valley <= 1'b0;
      ocp <= 1'b0;
    end else begin
      gate_q <= gate;
      ocp <= gate && ocp_req;
      if (gate) begin
        t <= 0;
        valley <= 1'b0;
      end else if (gate_q) begin
        t <= 1;
        valley <= !no_ring;
      end else if (t > 0) begin
        t <= t + 1;
        // Falls at DEMAG, then once per RING; a decayed ring reads low
        if (t >= DEMAG + 8 * RING || no_ring) begin
          valley <= 1'b0;
        end else if (t >= DEMAG) begin
          valley <= ((t - DEMAG) % RING) >= RING / 2;
        end
      end
    end
  end
endmodule

// >>> tb/tb_pfc_valley_switching_control.sv
// Purpose: Self-checking bench for the boost stage valley switching control.
// Assumes: ADC samples every 16 clocks; DC detection shortened to 200 cycles.
// Notes: Gains are zeroed first so the on-time cannot drift under the timing checks.
`timescale 1ns/100ps
module tb_pfc_valley_switching_control;
  import pfc_pkg::*;
  localparam int DEMAG = 40;
  localparam int RING = 20;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] address = 8'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [3:0] byteenable = 4'h0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest;
  logic valley_cmp, ocp_cmp, bus_range_narrow, boost_gate, half_cycle_pulse, dc_source;
  logic no_ring = 1'b0;
  logic ocp_req = 1'b0;
  logic bus_adc_valid = 1'b0;
  logic bus_adc_narrow = 1'b0;
  logic line_adc_valid = 1'b0;
  logic [11:0] bus_code = 12'h000;
  logic [11:0] line_code = 12'h800;
  logic [11:0] bus_val = 12'h700;
  logic [11:0] line_val = 12'h800;
  int bad_count = 0;
  int compares = 0;
  int cycles = 0;
  int ton = 0;

  always #4 clk = ~clk;

  pfc_valley_switching_control #(.DC_CYCLES(200)) dut (.clk(clk), .rstn(rstn), .address(address),
    .read(read), .write(write), .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .boost_sense_pin_valley(valley_cmp), .boost_sense_pin_ocp(ocp_cmp),
    .bus_adc_valid(bus_adc_valid), .bus_adc_narrow(bus_adc_narrow), .bus_sense_pin_code(bus_code),
    .bus_range_narrow(bus_range_narrow), .line_adc_valid(line_adc_valid),
    .line_sense_pin_code(line_code), .boost_gate(boost_gate), .half_cycle_pulse(half_cycle_pulse),
    .dc_source(dc_source));

  boost_stage_model #(.DEMAG(DEMAG), .RING(RING)) stage (.clk(clk), .rstn(rstn), .gate(boost_gate),
    .no_ring(no_ring), .ocp_req(ocp_req), .valley(valley_cmp), .ocp(ocp_cmp));

  // ADC samples follow the range the block asks for; narrow code 0x400 sits above steady entry
  always @(posedge clk) begin
    cycles <= cycles + 1;
    bus_adc_valid <= (cycles % 16 == 0);
    line_adc_valid <= (cycles % 16 == 8);
    bus_adc_narrow <= bus_range_narrow;
    bus_code <= bus_range_narrow ? 12'h400 : bus_val;
    line_code <= line_val;
    if (cycles == 40000) begin
      bad_count++;
      final_report();
    end
  end

  task automatic final_report;
    if (bad_count == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask

  task automatic chk_rng(input string name, input int lo, input int hi, input int got);
    compares++;
    if (got < lo || got > hi) begin
      bad_count++;
      $display("unexpected %s: expected %0d..%0d, seen %0d", name, lo, hi, got);
    end
  endtask

  // Request held until waitrequest is sampled low; the global cycle limit ends a hang
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    address <= a;
    writedata <= d;
    byteenable <= 4'hF;
    read <= !wr;
    write <= wr;
    do begin
      @(posedge clk);
    end while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0, q);
  endtask

  // One switching period from rise to rise: high and low cycle counts
  task automatic meas(output int hi, output int lo);
    hi = 0;
    lo = 0;
    // Start on a fresh rise, never in the middle of a pulse
    while (boost_gate !== 1'b0) @(posedge clk);
    while (boost_gate !== 1'b1) @(posedge clk);
    while (boost_gate === 1'b1) begin
      @(posedge clk);
      hi++;
    end
    while (boost_gate !== 1'b1) begin
      @(posedge clk);
      lo++;
    end
  endtask

  task automatic t_reset;
    logic [31:0] q;
    chk("gate at reset", 32'h0, boost_gate);
    chk("range at reset", 32'h0, bus_range_narrow);
    rd(OFS_CTRL, q);
    chk("ctrl reset", RST_CTRL, q);
    rd(OFS_BLANK, q);
    chk("blank reset", RST_BLANK, q);
    rd(8'h3C, q);
    chk("unmapped read", 32'h0, q);
  endtask

  task automatic t_soft;
    logic [31:0] q;
    int hi, lo, hi2, lo2;
    wr(OFS_GAINS, 32'h0);
    wr(OFS_CTRL, 32'h0000_0031);
    repeat (64) @(posedge clk);
    rd(OFS_STATUS, q);
    chk("mode below start", 32'h0, q[1:0]);
    chk("gate below start", 32'h0, boost_gate);
    bus_val <= 12'h900;
    repeat (64) @(posedge clk);
    rd(OFS_STATUS, q);
    chk("mode soft", 32'h1, q[1:0]);
    chk("soft valley", 32'h1, q[11:8]);
    chk("range soft", 32'h0, bus_range_narrow);
    rd(OFS_ON_TIME, q);
    ton = int'(q[15:0]);
    meas(hi, lo);
    meas(hi2, lo2);
    chk_rng("on time", ton - 2, ton + 2, hi);
    chk_rng("on time repeat", hi, hi, hi2);
    chk_rng("first valley off", DEMAG + 2, DEMAG + 8, lo);
    chk_rng("soft valley off", DEMAG + 2, DEMAG + 8, lo2);
    chk("dc source", 32'h1, dc_source);
  endtask

  task automatic t_abort;
    logic [31:0] q;
    logic [11:0] bad_line [2] = '{12'h050, 12'hF80};
    int hi;
    for (int i = 0; i < 2; i++) begin
      line_val <= bad_line[i];
      repeat (40) @(posedge clk);
      rd(OFS_STATUS, q);
      chk("line fault", 32'h1, q[4]);
      chk("aborted mode", 32'h0, q[1:0]);
      hi = 0;
      repeat (100) begin
        @(posedge clk);
        hi += (boost_gate !== 1'b0);
      end
      chk_rng("gate after abort", 0, 0, hi);
      line_val <= 12'h800;
      repeat (64) @(posedge clk);
      rd(OFS_STATUS, q);
      chk("soft again", 32'h1, q[1:0]);
    end
  endtask

  task automatic t_steady;
    logic [31:0] q;
    int hi, lo;
    wr(OFS_PERIOD_LIM, 32'hFFFF_0800);
    bus_val <= 12'hD80;
    repeat (1500) @(posedge clk);
    rd(OFS_STATUS, q);
    chk("mode steady", 32'h2, q[1:0]);
    chk("range steady", 32'h1, bus_range_narrow);
    chk("valley at max", 32'h3, q[11:8]);
    meas(hi, lo);
    chk_rng("third valley off", DEMAG + 2 * RING + 2, DEMAG + 2 * RING + 8, lo);
    wr(OFS_PERIOD_LIM, 32'h0020_0010);
    repeat (1000) @(posedge clk);
    rd(OFS_STATUS, q);
    chk("valley down", 32'h1, q[11:8]);
  endtask

  task automatic t_timeout_ocp;
    int hi, lo;
    no_ring <= 1'b1;
    wr(OFS_TIMEOUT, 32'(ton + 256));
    meas(hi, lo);
    meas(hi, lo);
    chk_rng("timeout period", ton + 254, ton + 260, hi + lo);
    no_ring <= 1'b0;
    wr(OFS_TIMEOUT, RST_TIMEOUT);
    wr(OFS_BLANK, 32'h0000_0004);
    ocp_req <= 1'b1;
    meas(hi, lo);
    meas(hi, lo);
    chk_rng("cut on time", 4, 9, hi);
    ocp_req <= 1'b0;
  endtask

  // A mains crossing right after a DC refresh, then the regulator with integral gain only
  task automatic t_line;
    logic [31:0] q;
    int n;
    int t0;
    while (half_cycle_pulse !== 1'b1) @(posedge clk);
    line_val <= 12'h020;
    n = 0;
    repeat (40) begin
      @(posedge clk);
      n += (half_cycle_pulse === 1'b1);
    end
    chk_rng("zero crossings", 1, 1, n);
    chk("dc after crossing", 32'h0, dc_source);
    line_val <= 12'h800;
    wr(OFS_GAINS, 32'h0000_0400);
    rd(OFS_ON_TIME, q);
    t0 = int'(q[15:0]);
    repeat (450) @(posedge clk);
    rd(OFS_ON_TIME, q);
    chk_rng("on time grows", t0 + 1, int'(ON_TIME_MAX), int'(q[15:0]));
  endtask

  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_soft();
    t_abort();
    t_steady();
    t_timeout_ocp();
    t_line();
    final_report();
  end
endmodule
